// *** core/psr_slave.sv ***
// Overview of operation
// - Frame starts on select falling while the clock rests low.
// - Three clock cycles carry six command/address bytes, DDR, first.
// - Bytes arrive most significant first, bit 47 on line 7.
// - Command bytes and write data are sampled on clock edges.
// - Strobe driven during command phase: high asks doubled latency.
// - Latency cycles follow the command, doubled when strobe was high.
// - Latency indication is driven before the first command byte.
// - Zero-latency write: strobe released, no mask, every byte stored.
// - Read data leave with the strobe as an edge-aligned reference.
// - Latency writes: strobe low stores byte, strobe high keeps it.
// - Words of 16 bits: first byte on rising, second on falling.
// - Select rising with clock idle ends the burst at once.
// - Clock may stop idle; logic needs no edge outside frames.
// - Bit 47 picks direction: one read, zero write.
// - Bit 46 picks space: zero memory, one register space.
// - Bit 45 picks burst: zero wrapped, one linear.
// - Bits 44 to 16 carry word address bits 31 to 3.
// - Bits 15 to 3 are ignored.
// - Bits 2 to 0 pick the start word in a half-page.
// - Half-page is eight words, page sixteen; no crossing latency here.
// - Read prefetch starts at decode; linear reads run without gaps.
// - Wrapped bursts circle their aligned group; linear bursts increment.
`timescale 1ns/100ps
`default_nettype none
`include "psr_params.svh"

module psr_slave #(
   parameter int            ADDR_W  = 10,
   parameter logic [15:0]   ID_WORD = `PSR_ID_WORD
) (
   // System clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Configuration, quasi-static, system domain
   input  wire logic [3:0]  latency_count_in,
   input  wire logic        extra_latency_in,
   input  wire logic [1:0]  wrap_sel_in,
   input  wire logic        zero_lat_wr_in,
   // Status toward the system
   output logic             frame_active_out,
   output logic             cmd_valid_out,
   output psr_pkg::psr_cmd_s cmd_out,
   // Link pins
   input  wire logic        link_ck_in,
   input  wire logic        cs_n_in,
   input  wire logic [7:0]  dq_in,
   output logic      [7:0]  dq_out,
   output logic             dq_oe_out,
   input  wire logic        read_write_strobe_in,
   output logic             read_write_strobe_out,
   output logic             read_write_strobe_oe_out
);
   import psr_pkg::*;

   // Frame state, cleared whenever select is high
   typedef struct packed {
      psr_state_e        st;
      logic [1:0]        cnt;
      logic [47:8]       ca_hi;
      logic              ext;
      logic [4:0]        lat_left;
      logic              rd;
      logic              reg_space;
      logic              linear;
      logic              zero_lat;
      logic [1:0]        wrap_sel;
      logic [ADDR_W-1:0] ptr;
      psr_byte_t         byte_a;
      logic              mask_a;
      psr_word_t         out_word;
   } psr_frame_s;

   // Command record, survives the frame for the system side
   typedef struct packed {
      logic     tgl;
      psr_cmd_s cmd;
   } psr_rec_s;

   // System-domain state
   typedef struct packed {
      logic     tgl_seen;
      logic     valid;
      psr_cmd_s cmd;
   } psr_sys_s;

   psr_frame_s f_r;
   psr_frame_s f_nxt;
   psr_rec_s   rec_r;
   psr_rec_s   rec_nxt;
   psr_sys_s   s_r;
   psr_sys_s   s_nxt;
   psr_byte_t  fall_byte_r;

   logic              frame_rst;
   logic              link_ck_n;
   logic [7:0]        cfg_q;
   logic [3:0]        cfg_lat;
   logic              cfg_ext;
   logic [1:0]        cfg_wrap;
   logic              cfg_zlw;
   logic [1:0]        sys_q;
   logic [47:0]       ca_full;
   logic [31:0]       word_addr;
   logic [3:0]        lat_cfg;
   logic [4:0]        lat_tot;
   logic [ADDR_W-1:0] ptr_next;
   psr_word_t         reg_word;
   psr_word_t         rd_word;

   psr_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

   // Select high clears the frame without needing a clock edge
   assign frame_rst = sys_rst_in | cs_n_in;
   assign link_ck_n = ~link_ck_in;

   // Configuration levels brought onto the link clock
   psr_sync #(.WIDTH(8)) u_cfg_sync (
      .clk_in (link_ck_in),
      .rst_in (sys_rst_in),
      .d_in   ({latency_count_in, extra_latency_in, wrap_sel_in,
                zero_lat_wr_in}),
      .q_out  (cfg_q)
   );
   assign cfg_lat  = cfg_q[7:4];
   assign cfg_ext  = cfg_q[3];
   assign cfg_wrap = cfg_q[2:1];
   assign cfg_zlw  = cfg_q[0];

   // Select level and command toggle brought onto the system clock
   psr_sync #(.WIDTH(2)) u_sys_sync (
      .clk_in (clk_in),
      .rst_in (sys_rst_in),
      .d_in   ({~cs_n_in, rec_r.tgl}),
      .q_out  (sys_q)
   );

   // Word store runs on the falling edge so the last byte of a
   // frame is written before select can rise
   psr_mem #(.ADDR_W(ADDR_W)) u_mem (
      .clk_in (link_ck_n),
      .port   (mem_bus.mem)
   );

   // Next burst address inside the wrap group or straight on
   function automatic logic [ADDR_W-1:0] psr_next_addr(
      input logic [ADDR_W-1:0] a,
      input logic              lin,
      input logic [1:0]        wsel
   );
      logic [ADDR_W-1:0] m;
      logic [ADDR_W-1:0] inc;
      m   = ADDR_W'((`PSR_WRAP_MIN_WORDS << wsel) - 7'h01);
      inc = a + ADDR_W'(1);
      if (lin) begin
         return inc;
      end
      return (a & ~m) | (inc & m);
   endfunction : psr_next_addr

   // Command fields, latency and read source
   always_comb begin
      ca_full   = {f_r.ca_hi, fall_byte_r};
      word_addr = {ca_full[`PSR_CA_ROW_HI:`PSR_CA_ROW_LO],
                   ca_full[`PSR_CA_COL_HI:`PSR_CA_COL_LO]};
      lat_cfg   = (cfg_lat == 4'h0) ? 4'h1 : cfg_lat;
      lat_tot   = f_r.ext ? {lat_cfg, 1'b0} : {1'b0, lat_cfg};
      ptr_next  = psr_next_addr(f_r.ptr, f_r.linear, f_r.wrap_sel);
      reg_word  = (f_r.ptr == '0) ? ID_WORD :
                  {10'h000, cfg_wrap, cfg_lat};
      rd_word   = f_r.reg_space ? reg_word : mem_bus.rdata;
   end

   // Link frame sequencing, one step per rising clock edge
   always_comb begin
      f_nxt   = f_r;
      rec_nxt = rec_r;
      case (f_r.st)
         PSR_ST_CA: begin
            // First rising edge after select fell opens the frame
            case (f_r.cnt)
               2'h0: begin
                  f_nxt.ca_hi[47:40] = dq_in;
                  f_nxt.ext          = cfg_ext;
               end
               2'h1: begin
                  f_nxt.ca_hi[39:32] = fall_byte_r;
                  f_nxt.ca_hi[31:24] = dq_in;
               end
               2'h2: begin
                  f_nxt.ca_hi[23:16] = fall_byte_r;
                  f_nxt.ca_hi[15:8]  = dq_in;
               end
               default: begin
                  // Sixth byte now sits in the falling-edge register
                  f_nxt.rd        = ca_full[`PSR_CA_DIR_BIT];
                  f_nxt.reg_space = ca_full[`PSR_CA_SPACE_BIT];
                  f_nxt.linear    = ca_full[`PSR_CA_BURST_BIT];
                  f_nxt.wrap_sel  = cfg_wrap;
                  f_nxt.ptr       = word_addr[ADDR_W-1:0];
                  rec_nxt.tgl     = ~rec_r.tgl;
                  rec_nxt.cmd     = '{rd:        ca_full[`PSR_CA_DIR_BIT],
                                      reg_space: ca_full[`PSR_CA_SPACE_BIT],
                                      linear:    ca_full[`PSR_CA_BURST_BIT],
                                      word_addr: word_addr};
                  if (!ca_full[`PSR_CA_DIR_BIT] && cfg_zlw) begin
                     // Write data already on the bus at this edge
                     f_nxt.st       = PSR_ST_WDATA;
                     f_nxt.zero_lat = 1'b1;
                     f_nxt.byte_a   = dq_in;
                     f_nxt.mask_a   = 1'b0;
                  end else begin
                     f_nxt.st       = PSR_ST_LAT;
                     f_nxt.lat_left = lat_tot - 5'h01;
                  end
               end
            endcase
            if (f_r.cnt != `PSR_CA_CYCLES) begin
               f_nxt.cnt = f_r.cnt + 2'h1;
            end
         end
         PSR_ST_LAT: begin
            if (f_r.lat_left == 5'h00) begin
               if (f_r.rd) begin
                  f_nxt.st       = PSR_ST_RDATA;
                  f_nxt.out_word = rd_word;
                  f_nxt.ptr      = ptr_next;
               end else begin
                  f_nxt.st     = PSR_ST_WDATA;
                  f_nxt.byte_a = dq_in;
                  f_nxt.mask_a = read_write_strobe_in;
               end
            end else begin
               f_nxt.lat_left = f_r.lat_left - 5'h01;
            end
         end
         PSR_ST_WDATA: begin
            // Previous word was stored on the last falling edge
            f_nxt.byte_a = dq_in;
            f_nxt.mask_a = f_r.zero_lat ? 1'b0
                                        : read_write_strobe_in;
            f_nxt.ptr    = ptr_next;
         end
         PSR_ST_RDATA: begin
            // Store read a half cycle ago, so no gap between words
            f_nxt.out_word = rd_word;
            f_nxt.ptr      = ptr_next;
         end
         default: begin
            f_nxt.st = PSR_ST_CA;
         end
      endcase
   end

   always_ff @(posedge link_ck_in or posedge frame_rst) begin
      if (frame_rst) begin
         f_r <= '{st: PSR_ST_CA, default: '0};
      end else begin
         f_r <= f_nxt;
      end
   end

   // Falling-edge byte of each command cycle
   always_ff @(negedge link_ck_in or posedge frame_rst) begin
      if (frame_rst) begin
         fall_byte_r <= `PSR_BYTE_RST;
      end else begin
         fall_byte_r <= dq_in;
      end
   end

   // Command record lives past the frame for the system side
   always_ff @(posedge link_ck_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rec_r <= '0;
      end else begin
         rec_r <= rec_nxt;
      end
   end

   // Store access: write on falling edge with byte B live on the bus
   always_comb begin
      mem_bus.wr_en   = (f_r.st == PSR_ST_WDATA) && !f_r.reg_space;
      mem_bus.addr    = f_r.ptr;
      mem_bus.wdata   = {f_r.byte_a, dq_in};
      mem_bus.byte_en = f_r.zero_lat ? 2'b11 :
                        ~{f_r.mask_a, read_write_strobe_in};
   end

   // Pin drivers; enables follow select directly so release is immediate
   always_comb begin
      read_write_strobe_out    = 1'b0;
      read_write_strobe_oe_out = 1'b0;
      dq_oe_out                = 1'b0;
      dq_out = link_ck_in ? f_r.out_word[15:8]
                          : f_r.out_word[7:0];
      if (!cs_n_in) begin
         case (f_r.st)
            PSR_ST_CA: begin
               // Driven before any command byte is known
               read_write_strobe_oe_out = 1'b1;
               read_write_strobe_out    = (f_r.cnt == 2'h0) ? cfg_ext
                                                            : f_r.ext;
            end
            PSR_ST_LAT: begin
               read_write_strobe_oe_out = f_r.rd;
            end
            PSR_ST_RDATA: begin
               read_write_strobe_oe_out = 1'b1;
               read_write_strobe_out    = link_ck_in;
               dq_oe_out                = 1'b1;
            end
            default: begin
               read_write_strobe_oe_out = 1'b0;
            end
         endcase
      end
   end

   // System side: pulse once per decoded command
   always_comb begin
      s_nxt          = s_r;
      s_nxt.tgl_seen = sys_q[0];
      s_nxt.valid    = sys_q[0] ^ s_r.tgl_seen;
      if (sys_q[0] ^ s_r.tgl_seen) begin
         s_nxt.cmd = rec_r.cmd; // Record settled before toggle
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign frame_active_out = sys_q[1];
   assign cmd_valid_out    = s_r.valid;
   assign cmd_out          = s_r.cmd;
endmodule : psr_slave

`default_nettype wire

// *** core/psr_params.svh ***
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// Command/address field positions
`define PSR_CA_DIR_BIT     47
`define PSR_CA_SPACE_BIT   46
`define PSR_CA_BURST_BIT   45
`define PSR_CA_ROW_HI      44
`define PSR_CA_ROW_LO      16
`define PSR_CA_COL_HI      2
`define PSR_CA_COL_LO      0

// Command/address phase length in link cycles
`define PSR_CA_CYCLES      2'h3

// Smallest wrap group is one half-page of eight words
`define PSR_WRAP_MIN_WORDS 7'h08

// Reset values
`define PSR_BYTE_RST       8'h00
`define PSR_WORD_RST       16'h0000

// Identification word, value is arbitrary
`define PSR_ID_WORD        16'h5a3c

`endif

// *** core/psr_pkg.sv ***
package psr_pkg;

   // Link-side frame phases
   typedef enum logic [1:0] {
      PSR_ST_CA    = 2'b00,
      PSR_ST_LAT   = 2'b01,
      PSR_ST_WDATA = 2'b10,
      PSR_ST_RDATA = 2'b11
   } psr_state_e;

   typedef logic [7:0]  psr_byte_t;
   typedef logic [15:0] psr_word_t;

   // Decoded command handed to the system side
   typedef struct packed {
      logic        rd;
      logic        reg_space;
      logic        linear;
      logic [31:0] word_addr;
   } psr_cmd_s;

endpackage : psr_pkg

// *** core/psr_mem_if.sv ***
`timescale 1ns/100ps
`default_nettype none

// Port between the link logic and the word store
interface psr_mem_if #(parameter int ADDR_W = 10);
   logic                 wr_en;
   logic [1:0]           byte_en;
   logic [ADDR_W-1:0]    addr;
   psr_pkg::psr_word_t   wdata;
   psr_pkg::psr_word_t   rdata;

   modport link (output wr_en, byte_en, addr, wdata, input rdata);
   modport mem  (input wr_en, byte_en, addr, wdata, output rdata);
endinterface : psr_mem_if

`default_nettype wire

// *** core/psr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module psr_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } psr_sync_s;

   psr_sync_s st_r;
   psr_sync_s st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_out = st_r.s2;
endmodule : psr_sync

`default_nettype wire

// *** core/psr_mem.sv ***
`timescale 1ns/100ps
`default_nettype none

module psr_mem #(
   parameter int ADDR_W = 10
) (
   // Store clock
   input  wire logic clk_in,
   // Access port
   psr_mem_if.mem    port
);
   import psr_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   psr_word_t rdata_r;

   // One array per byte lane, so each lane has a single writer and a
   // masked byte stays intact; read is registered, one word per edge
   for (genvar b = 0; b < 2; b++) begin : g_lane
      // Array has no reset; contents are undefined until written
      psr_byte_t lane_q [DEPTH];

      always_ff @(posedge clk_in) begin
         if (port.wr_en && port.byte_en[b]) begin
            lane_q[port.addr] <= port.wdata[8*b +: 8];
         end
         rdata_r[8*b +: 8] <= lane_q[port.addr];
      end
   end

   assign port.rdata = rdata_r;
endmodule : psr_mem

`default_nettype wire

// *** testbench/psr_slave_chk.sv ***
`timescale 1ns/100ps
`default_nettype none

module psr_slave_chk (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              sys_rst_in,
   // Link pins
   input  wire logic              link_ck_in,
   input  wire logic              cs_n_in,
   input  wire logic              dq_oe_out,
   input  wire logic              read_write_strobe_out,
   input  wire logic              read_write_strobe_oe_out,
   // System side
   input  wire logic              frame_active_out,
   input  wire logic              cmd_valid_out,
   input  wire psr_pkg::psr_cmd_s cmd_out
);
   import psr_pkg::*;

   // Whole checker lives in the system clock domain
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   // Pin drivers and strobe behaviour
   chk_idle_float:
   assert property (cs_n_in |-> !dq_oe_out && !read_write_strobe_oe_out)
      else $error("pin driven while deselected");
   chk_strobe_early:
   assert property ($fell(cs_n_in) |-> read_write_strobe_oe_out)
      else $error("strobe not driven at frame start");
   chk_read_strobe:
   assert property (dq_oe_out |-> read_write_strobe_oe_out &&
                    read_write_strobe_out == link_ck_in)
      else $error("read strobe does not follow link clock");

   // Decoded command toward the system
   chk_cmd_pulse:
   assert property (cmd_valid_out |=> !cmd_valid_out)
      else $error("command strobe longer than one cycle");
   chk_cmd_hold:
   assert property (!cmd_valid_out |-> $stable(cmd_out))
      else $error("command changed without strobe");
   chk_cmd_frame:
   assert property ($rose(cmd_valid_out) |-> frame_active_out)
      else $error("command outside a frame");

   // Frame activity through the synchroniser
   chk_act_rise:
   assert property (!cs_n_in [*5] |-> frame_active_out)
      else $error("frame start not reported");
   chk_act_fall:
   assert property (cs_n_in [*5] |-> !frame_active_out)
      else $error("frame end not reported");

   // Main scenarios
   cov_read:  cover property (cmd_valid_out && cmd_out.rd);
   cov_write: cover property (cmd_valid_out && !cmd_out.rd);
   cov_data:  cover property ($rose(dq_oe_out));
endmodule : psr_slave_chk

bind psr_slave psr_slave_chk psr_slave_chk_inst (
   .clk_in                  (clk_in),
   .sys_rst_in              (sys_rst_in),
   .link_ck_in              (link_ck_in),
   .cs_n_in                 (cs_n_in),
   .dq_oe_out               (dq_oe_out),
   .read_write_strobe_out   (read_write_strobe_out),
   .read_write_strobe_oe_out(read_write_strobe_oe_out),
   .frame_active_out        (frame_active_out),
   .cmd_valid_out           (cmd_valid_out),
   .cmd_out                 (cmd_out)
);

`default_nettype wire

// *** testbench/psr_host.sv ***
`timescale 1ns/100ps
`default_nettype none

module psr_host (
   // Link pins toward the slave
   output logic            link_ck_out,
   output logic            cs_n_out,
   output logic      [7:0] dq_out,
   output logic            rw_out,
   // Slave drivers
   input  wire logic [7:0] s_dq_in,
   input  wire logic       s_dq_oe_in,
   input  wire logic       s_rw_in,
   input  wire logic       s_rw_oe_in
);
   logic [7:0]  hd;
   logic        hoe;
   logic        hs;
   logic        hsoe;
   logic        lat_hi;
   logic [15:0] wd [0:15];
   logic [1:0]  wm [0:15];
   logic [15:0] rd [0:15];

   // Undriven wires show the inverse of the host data, not a bus-keeper value
   assign dq_out = s_dq_oe_in ? s_dq_in : (hoe ? hd : ~hd);
   assign rw_out = s_rw_oe_in ? s_rw_in : (hsoe ? hs : ~hs);

   // Clock stands low outside frames
   initial begin
      link_ck_out = 1'b0;
      cs_n_out = 1'b1;
      hoe = 1'b0;
      hsoe = 1'b0;
      hd = 8'h00;
      hs = 1'b0;
   end

   // Data changes mid-phase, so edges sit centred
   task automatic half(input logic [7:0] d, input logic m);
      hd = d;
      hs = m;
      #7.5;
      link_ck_out = ~link_ck_out;
      #7.5;
   endtask : half

   // Complete frame: command, latency, n words
   task automatic xfer(input logic [47:0] ca, input int lat,
                       input logic zl, input int n);
      int t;
      hoe = 1'b1;
      hsoe = 1'b0;
      cs_n_out = 1'b0;
      #15;
      for (int i = 0; i < 6; i++) begin
         half(ca[47-8*i -: 8], 1'b0);
         if (i == 0) lat_hi = rw_out;
      end
      t = (zl && !ca[47]) ? 0 : ((lat == 0) ? 1 : lat) * (lat_hi ? 2 : 1);
      hoe = !ca[47];
      for (int i = 0; i < 2 * t; i++) half(8'h00, 1'b0);
      hsoe = !ca[47] && !zl;
      for (int i = 0; i < n; i++) begin
         half(wd[i][15:8], wm[i][1]);
         rd[i][15:8] = dq_out;
         half(wd[i][7:0], wm[i][0]);
         rd[i][7:0] = dq_out;
      end
      #7.5 cs_n_out = 1'b1;
      hoe = 1'b0;
      hsoe = 1'b0;
      #30;
   endtask : xfer

   // Frame cut off inside the command phase
   task automatic abort();
      hoe = 1'b1;
      cs_n_out = 1'b0;
      #15;
      for (int i = 0; i < 6; i++) half(8'hff, 1'b0);
      #7.5 cs_n_out = 1'b1;
      hoe = 1'b0;
      #30;
   endtask : abort
endmodule : psr_host

`default_nettype wire

// *** testbench/tb_psr_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_psr_slave;
   import psr_pkg::*;
   localparam logic [15:0] ID_W = 16'h3c5a; // Arbitrary identity value

   logic        clk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [3:0]  cfg_lat = 4'h2;
   logic        cfg_ext = 1'b0;
   logic [1:0]  cfg_wrap = 2'h0;
   logic        cfg_zl = 1'b0;
   wire logic   link_ck, cs_n, rw_w, rw_o, rw_oe, dq_oe, f_act, c_val;
   wire logic [7:0] dq_w, dq_o;
   psr_cmd_s    cmd;
   logic [15:0] em [0:31];
   logic [15:0] ncmd = 16'h0000;
   int          bad_count = 0;
   int          tests_run = 0;

   always #10 clk_in = ~clk_in;

   psr_slave #(.ADDR_W(10), .ID_WORD(ID_W)) psr_slave_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .latency_count_in(cfg_lat), .extra_latency_in(cfg_ext),
      .wrap_sel_in(cfg_wrap), .zero_lat_wr_in(cfg_zl),
      .frame_active_out(f_act), .cmd_valid_out(c_val), .cmd_out(cmd),
      .link_ck_in(link_ck), .cs_n_in(cs_n), .dq_in(dq_w),
      .dq_out(dq_o), .dq_oe_out(dq_oe), .read_write_strobe_in(rw_w),
      .read_write_strobe_out(rw_o), .read_write_strobe_oe_out(rw_oe));

   psr_host psr_host_inst (
      .link_ck_out(link_ck), .cs_n_out(cs_n), .dq_out(dq_w),
      .rw_out(rw_w), .s_dq_in(dq_o), .s_dq_oe_in(dq_oe),
      .s_rw_in(rw_o), .s_rw_oe_in(rw_oe));

   // Command strobes seen
   always @(negedge clk_in) if (c_val === 1'b1) ncmd <= ncmd + 16'h0001;

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   function automatic logic [47:0] ca_mk(input logic r, s, l,
      input logic [31:0] a, input logic [12:0] v);
      return {r, s, l, a[31:3], v, a[2:0]};
   endfunction : ca_mk

   // New settings need link edges to land, so an aborted frame follows
   task automatic setcfg(input logic [3:0] l, input logic x, z,
                         input logic [1:0] w);
      logic [15:0] c0;
      @(negedge clk_in);
      cfg_lat <= l;
      cfg_ext <= x;
      cfg_zl <= z;
      cfg_wrap <= w;
      repeat (4) @(negedge clk_in);
      c0 = ncmd;
      psr_host_inst.abort();
      repeat (10) @(negedge clk_in);
      chk(ncmd, c0);
   endtask : setcfg

   task automatic run(input logic [47:0] ca, input int n);
      logic [15:0] c0;
      c0 = ncmd;
      psr_host_inst.xfer(ca, int'(cfg_lat), cfg_zl, n);
      repeat (10) @(negedge clk_in);
      chk(ncmd, c0 + 16'h0001);
      chk(cmd, {ca[47:45], ca[44:16], ca[2:0]});
   endtask : run

   // Read words against the model, group of gs words from g0
   task automatic rdcmp(input int g0, gs, st, n);
      for (int i = 0; i < n; i++)
         chk(psr_host_inst.rd[i], em[g0 + (st + i) % gs]);
   endtask : rdcmp

   task automatic summarize();
      $display("Checks %0d, errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // Hang guard, far beyond the expected run of under ten us
   initial begin
      #200000;
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end

   // Test sequence
   initial begin
      repeat (16) @(negedge clk_in);
      sys_rst_in = 1'b0;
      setcfg(4'h2, 1'b0, 1'b0, 2'h0);
      for (int i = 0; i < 8; i++) begin
         em[16+i] = {8'hc0 + 8'(i), 8'h30 + 8'(i)};
         psr_host_inst.wd[i] = em[16+i];
         psr_host_inst.wm[i] = 2'b00;
      end
      run(ca_mk(1'b0, 1'b0, 1'b1, 32'h10, 13'h0), 8);
      psr_host_inst.wd[0] = 16'haaaa;
      psr_host_inst.wm[0] = 2'b01;
      psr_host_inst.wd[1] = 16'h5555;
      psr_host_inst.wm[1] = 2'b10;
      em[17][15:8] = 8'haa;
      em[18][7:0] = 8'h55;
      run(ca_mk(1'b0, 1'b0, 1'b1, 32'h11, 13'h0), 2);
      run(ca_mk(1'b1, 1'b0, 1'b0, 32'h16, 13'h1abc), 10);
      rdcmp(16, 8, 6, 10);
      setcfg(4'h1, 1'b1, 1'b0, 2'h0);
      run(ca_mk(1'b1, 1'b0, 1'b1, 32'h11, 13'h0), 3);
      chk(psr_host_inst.lat_hi, 1'b1);
      rdcmp(16, 32, 1, 3);
      setcfg(4'h1, 1'b1, 1'b1, 2'h0);
      psr_host_inst.wd[0] = 16'h1234;
      psr_host_inst.wd[1] = 16'hfedc;
      psr_host_inst.wm[0] = 2'b00;
      psr_host_inst.wm[1] = 2'b00;
      em[20] = 16'h1234;
      em[21] = 16'hfedc;
      run(ca_mk(1'b0, 1'b0, 1'b1, 32'h14, 13'h0), 2);
      setcfg(4'h3, 1'b0, 1'b0, 2'h2);
      run(ca_mk(1'b1, 1'b1, 1'b1, 32'h0, 13'h0), 2);
      chk(psr_host_inst.rd[0], ID_W);
      chk(psr_host_inst.rd[1], {10'h000, 2'h2, 4'h3});
      psr_host_inst.wd[0] = 16'h0f0f;
      run(ca_mk(1'b0, 1'b1, 1'b1, 32'h10, 13'h0), 1);
      run(ca_mk(1'b1, 1'b0, 1'b1, 32'h10, 13'h0), 8);
      rdcmp(16, 32, 0, 8);
      summarize();
   end
endmodule : tb_psr_slave

`default_nettype wire
